// >>> design/scr_pkg.sv
// Shared constants for the synthesizer mid-map configuration registers.
// Assumes a 32-bit AXI4-Lite master with a 10-bit byte address.
package scr_pkg;

  // Bus widths and responses
  localparam int unsigned SCR_ADDR_W = 10;
  localparam int unsigned SCR_DATA_W = 32;
  localparam int unsigned SCR_REG_W = 16;
  localparam logic [1:0] SCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCR_RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] SCR_IDX_MOD_CTRL = 8'h2c, SCR_IDX_OUT_A = 8'h2d,
    SCR_IDX_OUT_B = 8'h2e, SCR_IDX_2F = 8'h2f, SCR_IDX_30 = 8'h30,
    SCR_IDX_31 = 8'h31, SCR_IDX_32 = 8'h32, SCR_IDX_33 = 8'h33,
    SCR_IDX_34 = 8'h34, SCR_IDX_35 = 8'h35, SCR_IDX_36 = 8'h36,
    SCR_IDX_37 = 8'h37, SCR_IDX_38 = 8'h38, SCR_IDX_39 = 8'h39,
    SCR_IDX_PIN_IGN = 8'h3a, SCR_IDX_LD_KIND = 8'h3b, SCR_IDX_LD_WAIT = 8'h3c,
    SCR_IDX_3D = 8'h3d, SCR_IDX_3E = 8'h3e, SCR_IDX_3F = 8'h3f,
    SCR_IDX_40 = 8'h40, SCR_IDX_41 = 8'h41, SCR_IDX_42 = 8'h42,
    SCR_IDX_43 = 8'h43, SCR_IDX_44 = 8'h44;
  localparam logic [7:0] SCR_IDX_IRQ_STAT = 8'h50;
  localparam logic [7:0] SCR_IDX_IRQ_MASK = 8'h51;
  localparam logic [7:0] SCR_IDX_FIRST = SCR_IDX_MOD_CTRL;
  localparam logic [7:0] SCR_IDX_LAST = SCR_IDX_44;
  localparam int SCR_NUM_REGS = 25;

  // Reset values in index order, first entry at SCR_IDX_FIRST
  localparam logic [15:0] SCR_RESET [SCR_NUM_REGS] = '{
    16'h22a2, 16'hc622, 16'h07f0, 16'h0300, 16'h03e0, 16'h4180, 16'h0080,
    16'h0080, 16'h0420, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h8001, 16'h0001, 16'h03e8, 16'h00a8, 16'h00ae, 16'h0000, 16'h1388,
    16'h0000, 16'h0140, 16'h0000, 16'h03e8};

  // Field positions
  localparam int SCR_MOD_RUN_BIT = 5;
  localparam int SCR_MOD_ORDER_LSB = 0;
  localparam int SCR_OUTA_SRC_LSB = 11;
  localparam int SCR_SECOND_OUTPUT_DRIVE_CURRENT_LSB = 0;
  localparam int SCR_OUTB_SRC_LSB = 0;
  localparam int SCR_PIN_IGN_BIT = 15;
  localparam int SCR_LD_KIND_BIT = 0;

  // Interrupt status bits
  localparam int SCR_IRQ_W = 4;
  localparam int SCR_IRQ_LOCK_UP = 0;
  localparam int SCR_IRQ_LOCK_DOWN = 1;
  localparam int SCR_IRQ_PIN_DROP = 2;
  localparam int SCR_IRQ_BAD_CODE = 3;

  typedef enum logic [2:0] {
    SCR_ORD_INTEGER = 3'h0,
    SCR_ORD_FIRST = 3'h1,
    SCR_ORD_SECOND = 3'h2,
    SCR_ORD_THIRD = 3'h3
  } scr_order_t;

  typedef enum logic [1:0] {
    SCR_SRC_CHDIV = 2'h0,
    SCR_SRC_OSC = 2'h1,
    SCR_SRC_REFPULSE = 2'h2,
    SCR_SRC_RESERVED = 2'h3
  } scr_source_t;

  // Word index carried by a byte address
  function automatic logic [7:0] scr_index(input logic [SCR_ADDR_W-1:0] addr);
    scr_index = addr[SCR_ADDR_W-1:2];
  endfunction : scr_index

  // True when an index falls inside the configuration window
  function automatic logic scr_in_map(input logic [7:0] idx);
    scr_in_map = (idx >= SCR_IDX_FIRST) && (idx <= SCR_IDX_LAST);
  endfunction : scr_in_map

endpackage : scr_pkg

// >>> design/scr_axil_slave.sv
// AXI4-Lite slave front end for the configuration registers.
// Assumes the register core answers index lookups combinationally.
`timescale 1ns/1ps
`default_nettype none
module scr_axil_slave
  import scr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [SCR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SCR_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SCR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [SCR_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_idx,
  output logic [15:0] wr_data,
  output logic [1:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic rd_ok
);

  // Address and data are taken together, so no skid storage is needed
  assign awready = ce & awvalid & wvalid & ~bvalid;
  assign wready = awready;
  assign wr_en = awready;
  assign wr_idx = scr_index(awaddr);
  assign wr_data = wdata[15:0];
  assign wr_strb = wstrb[1:0];
  assign arready = ce & arvalid & ~rvalid;
  assign rd_idx = scr_index(araddr);

  // Write response follows the accepted pair by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= SCR_RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_en)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? SCR_RESP_OKAY : SCR_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // Read data is captured at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rresp <= SCR_RESP_OKAY;
      rdata <= '0;
    end
    else if (ce)
    begin
      if (arready)
      begin
        rvalid <= 1'b1;
        rresp <= rd_ok ? SCR_RESP_OKAY : SCR_RESP_SLVERR;
        rdata <= {16'h0000, rd_data};
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

endmodule : scr_axil_slave
`default_nettype wire

// >>> design/scr_lock_detect.sv
// Lock detector: calibration wait counter and tuning-voltage qualifier.
// Assumes one quarter_tick pulse per quarter phase-detector period.
`timescale 1ns/1ps
`default_nettype none
module scr_lock_detect
  import scr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic cal_done,
  input wire logic quarter_tick,
  input wire logic [15:0] wait_count,
  input wire logic kind,
  input wire logic vtune_ok,
  output logic lock_detect
);

  typedef enum logic [1:0] {
    SCR_LD_IDLE = 2'b00,
    SCR_LD_WAIT = 2'b01,
    SCR_LD_LOCK = 2'b10
  } scr_ld_state_t;

  scr_ld_state_t state_q;
  logic [15:0] cnt_q;

  // Calibration lock: wait the programmed ticks after calibration ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SCR_LD_IDLE;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      unique case (state_q)
        SCR_LD_IDLE:
          if (cal_done)
          begin
            cnt_q <= '0;
            state_q <= (wait_count == 16'h0000) ? SCR_LD_LOCK : SCR_LD_WAIT;
          end
        SCR_LD_WAIT:
          if (!cal_done)
            state_q <= SCR_LD_IDLE;
          else if (quarter_tick)
          begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 >= wait_count)
              state_q <= SCR_LD_LOCK;
          end
        SCR_LD_LOCK:
          if (!cal_done)
            state_q <= SCR_LD_IDLE;
        default:
          state_q <= SCR_LD_IDLE;
      endcase
    end
  end

  // Output kind: calibration only, or also tuning voltage in range
  // Calibration is looked at again so a restart in the lock cycle cannot raise lock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_detect <= 1'b0;
    else if (ce)
      lock_detect <= (state_q == SCR_LD_LOCK) && cal_done && (!kind || vtune_ok);
  end

  sequence seq_tick_short;
    ce && state_q == SCR_LD_WAIT && cal_done && quarter_tick && (cnt_q + 16'h0001 < wait_count);
  endsequence

  AST_LD_WAIT_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_tick_short |=> state_q == SCR_LD_WAIT)
    else $error("Lock wait ended before the programmed count");

  AST_LD_NEEDS_CAL: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(lock_detect) |-> $past(state_q) == SCR_LD_LOCK && $past(cal_done))
    else $error("Lock rose without finished calibration");

  AST_LD_VTUNE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && kind && !vtune_ok |=> !lock_detect)
    else $error("Combined lock high with tuning voltage out of range");

  AST_LD_CAL_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !kind && state_q == SCR_LD_LOCK && cal_done |=> lock_detect)
    else $error("Calibration-only lock failed to follow calibration lock");

endmodule : scr_lock_detect
`default_nettype wire

// >>> design/scr_config_regs.sv
// Mid-map configuration register bank of the wideband synthesizer.
// Assumes aclk from the device state machine and an AXI4-Lite master.
//
// Contract
// - Modulator reset bit is active low: zero holds reset, one runs.
// - Modulator order: 0 integer, 1 first, 2 second, 3 third; 4-7 unused.
// - First output source bits 12-11: 0 channel divider, 1 oscillator.
// - Second output drive current, six bits: zero least, 0x1F most.
// - Second output source: 0 divider, 1 oscillator, 2 reference pulse.
// - Ignore bit with phase alignment off disregards sync and request pins.
// - Lock kind zero: calibration only; one: calibration plus tuning voltage.
// - Calibration lock rises after calibration ends and the wait expires.
// - Combined lock needs calibration lock and tuning voltage in limits.
// - Sixteen-bit lock wait counts quarter phase-detector periods.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs
  import scr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [SCR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SCR_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SCR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [SCR_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic oscillator_phase_align_enable,
  input wire logic sync_pin,
  input wire logic reference_request_pin,
  input wire logic oscillator_calibration_done,
  input wire logic quarter_pd_tick,
  input wire logic tuning_voltage_ok,
  output logic modulator_reset_low,
  output logic [2:0] modulator_order_select,
  output logic [1:0] first_output_source,
  output logic [1:0] second_output_source,
  output logic [5:0] second_output_drive_current,
  output logic sync_pin_used,
  output logic reference_request_used,
  output logic lock_detect,
  output logic irq
);

  // Slots of the words that steer the block
  localparam logic [4:0] SLOT_MOD = 5'(SCR_IDX_MOD_CTRL - SCR_IDX_FIRST);
  localparam logic [4:0] SLOT_OUT_A = 5'(SCR_IDX_OUT_A - SCR_IDX_FIRST);
  localparam logic [4:0] SLOT_OUT_B = 5'(SCR_IDX_OUT_B - SCR_IDX_FIRST);
  localparam logic [4:0] SLOT_PIN = 5'(SCR_IDX_PIN_IGN - SCR_IDX_FIRST);
  localparam logic [4:0] SLOT_KIND = 5'(SCR_IDX_LD_KIND - SCR_IDX_FIRST);
  localparam logic [4:0] SLOT_WAIT = 5'(SCR_IDX_LD_WAIT - SCR_IDX_FIRST);

  logic [15:0] regs_q [SCR_NUM_REGS];
  logic [SCR_IRQ_W-1:0] irq_stat_q;
  logic [SCR_IRQ_W-1:0] irq_mask_q;
  logic [SCR_IRQ_W-1:0] irq_set;
  logic [SCR_IRQ_W-1:0] irq_clr;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_idx;
  logic [15:0] rd_data;
  logic rd_ok;
  logic [2:0] order_raw;
  logic disregard;
  logic lock_prev_q;
  logic bad_code;

  // Bus front end
  scr_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Configuration words; byte lanes above bit 15 have nothing behind them
  genvar g;
  for (g = 0; g < SCR_NUM_REGS; g++)
  begin : g_reg
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        regs_q[g] <= SCR_RESET[g];
      else if (ce && wr_en && wr_idx == SCR_IDX_FIRST + 8'(g))
      begin
        if (wr_strb[0])
          regs_q[g][7:0] <= wr_data[7:0];
        if (wr_strb[1])
          regs_q[g][15:8] <= wr_data[15:8];
      end
    end
  end

  // Writes outside the window get an error response, except to the two interrupt words
  assign wr_ok = scr_in_map(wr_idx) || wr_idx == SCR_IDX_IRQ_STAT
    || wr_idx == SCR_IDX_IRQ_MASK;

  // Read mux; unmapped words read zero with an error response
  always_comb
  begin
    rd_data = 16'h0000;
    rd_ok = 1'b1;
    if (scr_in_map(rd_idx))
      rd_data = regs_q[5'(rd_idx - SCR_IDX_FIRST)];
    else if (rd_idx == SCR_IDX_IRQ_STAT)
      rd_data = {12'h000, irq_stat_q};
    else if (rd_idx == SCR_IDX_IRQ_MASK)
      rd_data = {12'h000, irq_mask_q};
    else
      rd_ok = 1'b0;
  end

  // Direct field outputs, each a slice of a stored word
  assign modulator_reset_low = regs_q[SLOT_MOD][SCR_MOD_RUN_BIT];
  assign first_output_source = regs_q[SLOT_OUT_A][SCR_OUTA_SRC_LSB +: 2];
  assign second_output_drive_current = regs_q[SLOT_OUT_A][SCR_SECOND_OUTPUT_DRIVE_CURRENT_LSB +: 6];
  assign second_output_source = regs_q[SLOT_OUT_B][SCR_OUTB_SRC_LSB +: 2];
  assign order_raw = regs_q[SLOT_MOD][SCR_MOD_ORDER_LSB +: 3];

  // Unused order codes run the loop as integer, the safest fallback
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      modulator_order_select <= SCR_ORD_INTEGER;
    else if (ce)
      modulator_order_select <= (order_raw > SCR_ORD_THIRD) ? SCR_ORD_INTEGER : order_raw;
  end

  // Pins are only disregarded while phase alignment is off
  assign disregard = regs_q[SLOT_PIN][SCR_PIN_IGN_BIT] && !oscillator_phase_align_enable;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_pin_used <= 1'b0;
      reference_request_used <= 1'b0;
    end
    else if (ce)
    begin
      sync_pin_used <= sync_pin && !disregard;
      reference_request_used <= reference_request_pin && !disregard;
    end
  end

  // Lock detector
  scr_lock_detect u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cal_done(oscillator_calibration_done),
    .quarter_tick(quarter_pd_tick),
    .wait_count(regs_q[SLOT_WAIT]),
    .kind(regs_q[SLOT_KIND][SCR_LD_KIND_BIT]),
    .vtune_ok(tuning_voltage_ok),
    .lock_detect(lock_detect)
  );

  // Flag a write that leaves an unused or reserved code in a select field
  always_comb
  begin
    bad_code = 1'b0;
    if (wr_en && wr_idx == SCR_IDX_MOD_CTRL && wr_strb[0])
      bad_code = wr_data[SCR_MOD_ORDER_LSB +: 3] > SCR_ORD_THIRD;
    else if (wr_en && wr_idx == SCR_IDX_OUT_A && wr_strb[1])
      bad_code = wr_data[SCR_OUTA_SRC_LSB +: 2] > SCR_SRC_OSC;
    else if (wr_en && wr_idx == SCR_IDX_OUT_B && wr_strb[0])
      bad_code = wr_data[SCR_OUTB_SRC_LSB +: 2] == SCR_SRC_RESERVED;
  end

  // Interrupt events
  always_comb
  begin
    irq_set = '0;
    irq_set[SCR_IRQ_LOCK_UP] = lock_detect && !lock_prev_q;
    irq_set[SCR_IRQ_LOCK_DOWN] = !lock_detect && lock_prev_q;
    irq_set[SCR_IRQ_PIN_DROP] = disregard && (sync_pin || reference_request_pin);
    irq_set[SCR_IRQ_BAD_CODE] = bad_code;
    irq_clr = '0;
    if (wr_en && wr_idx == SCR_IDX_IRQ_STAT && wr_strb[0])
      irq_clr = wr_data[SCR_IRQ_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_prev_q <= 1'b0;
    else if (ce)
      lock_prev_q <= lock_detect;
  end

  // Sticky status, write one to clear; a new event beats its own clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= '0;
    else if (ce)
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_q <= '0;
    else if (ce && wr_en && wr_idx == SCR_IDX_IRQ_MASK && wr_strb[0])
      irq_mask_q <= wr_data[SCR_IRQ_W-1:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_wr_mod;
    ce && wr_en && wr_idx == SCR_IDX_MOD_CTRL && wr_strb[0];
  endsequence

  sequence seq_wr_out_a;
    ce && wr_en && wr_idx == SCR_IDX_OUT_A && wr_strb == 2'b11;
  endsequence

  sequence seq_wr_out_b;
    ce && wr_en && wr_idx == SCR_IDX_OUT_B && wr_strb[0];
  endsequence

  AST_MOD_RESET_BIT: assert property (
    seq_wr_mod |=> modulator_reset_low == $past(wr_data[SCR_MOD_RUN_BIT]))
    else $error("Modulator reset bit did not follow the write");

  AST_ORDER_RANGE: assert property (
    seq_wr_mod ##1 ce |=> modulator_order_select ==
      (($past(wr_data[SCR_MOD_ORDER_LSB +: 3], 2) > SCR_ORD_THIRD) ? SCR_ORD_INTEGER
        : $past(wr_data[SCR_MOD_ORDER_LSB +: 3], 2)))
    else $error("Modulator order does not match the written code");

  AST_OUTA_SOURCE: assert property (
    seq_wr_out_a |=> first_output_source == $past(wr_data[SCR_OUTA_SRC_LSB +: 2]))
    else $error("First output source did not follow the write");

  AST_OUTB_CURRENT: assert property (
    seq_wr_out_a |=> second_output_drive_current == $past(wr_data[SCR_SECOND_OUTPUT_DRIVE_CURRENT_LSB +: 6]))
    else $error("Second output drive current did not follow the write");

  AST_OUTB_SOURCE: assert property (
    seq_wr_out_b |=> second_output_source == $past(wr_data[SCR_OUTB_SRC_LSB +: 2]))
    else $error("Second output source did not follow the write");

  AST_PINS_DISREGARDED: assert property (
    ce && regs_q[SLOT_PIN][SCR_PIN_IGN_BIT] && !oscillator_phase_align_enable
      |=> !sync_pin_used && !reference_request_used)
    else $error("A pin was passed on while it should be disregarded");

  AST_PINS_PASSED: assert property (
    ce && oscillator_phase_align_enable && sync_pin |=> sync_pin_used)
    else $error("Sync pin dropped while phase alignment is enabled");

  AST_RESET_LOAD: assert property (disable iff (1'b0)
    !aresetn |=> regs_q[SLOT_OUT_A] == SCR_RESET[SLOT_OUT_A]
      && regs_q[SLOT_WAIT] == SCR_RESET[SLOT_WAIT])
    else $error("Register did not load its reset value");

  AST_WORD_HOLDS: assert property (
    !(wr_en && ce) |=> $stable(regs_q[SLOT_OUT_B]))
    else $error("Register changed without a write");

  AST_IRQ_STICKY: assert property (
    ce && irq_set[SCR_IRQ_BAD_CODE] |=> irq_stat_q[SCR_IRQ_BAD_CODE])
    else $error("Interrupt event was lost");

endmodule : scr_config_regs
`default_nettype wire

// >>> verif/scr_config_regs_tb.sv
// Self-checking bench for the mid-map configuration register bank.
// Assumes the bank answers AXI4-Lite and all pins sit in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs_tb
  import scr_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [SCR_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [SCR_DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic phase_en = 1'b0, sync_in = 1'b0, req_in = 1'b0, cal_done = 1'b0;
  logic tick = 1'b0, vtune = 1'b0;
  logic mod_rst_n, sync_used, req_used, lock, irq;
  logic [2:0] order;
  logic [1:0] src_a, src_b;
  logic [5:0] drive;
  int miscompares = 0;
  int checks_done = 0;

  scr_config_regs i_scr_config_regs (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .oscillator_phase_align_enable(phase_en),
    .sync_pin(sync_in), .reference_request_pin(req_in),
    .oscillator_calibration_done(cal_done), .quarter_pd_tick(tick),
    .tuning_voltage_ok(vtune), .modulator_reset_low(mod_rst_n),
    .modulator_order_select(order), .first_output_source(src_a),
    .second_output_source(src_b), .second_output_drive_current(drive),
    .sync_pin_used(sync_used), .reference_request_used(req_used),
    .lock_detect(lock), .irq(irq));

  // Free-running 40 MHz clock
  always #12.5 aclk = ~aclk;

  // One comparison, counted; four-state equality so an unknown bit matches only the same unknown bit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // Write one word; request held until taken, then one idle edge
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // Read one word and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [15:0] ed, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, {16'h0000, ed});
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Synchronous reset held for five edges
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // Every word back at its table value, interrupt registers clear
  task automatic t_reset_values();
    for (int i = 0; i < SCR_NUM_REGS; i++)
      rd(SCR_IDX_FIRST + 8'(i), SCR_RESET[i], SCR_RESP_OKAY);
    rd(SCR_IDX_IRQ_STAT, 16'h0000, SCR_RESP_OKAY);
    rd(SCR_IDX_IRQ_MASK, 16'h0000, SCR_RESP_OKAY);
    chk(order, 3'h2);
    chk(mod_rst_n, 1'b1);
  endtask : t_reset_values

  // Modulator order codes, unused codes fall back to integer, then hold in reset
  task automatic t_modulator();
    for (int o = 0; o < 8; o++)
    begin
      wr(SCR_IDX_MOD_CTRL, 16'h2220 | 16'(o), SCR_RESP_OKAY);
      chk(order, (o < 4) ? 3'(o) : 3'h0);
      chk(mod_rst_n, 1'b1);
    end
    wr(SCR_IDX_MOD_CTRL, 16'h2203, SCR_RESP_OKAY);
    chk(mod_rst_n, 1'b0);
    chk(order, 3'h3);
  endtask : t_modulator

  // Software-mandated values stored and read back, outputs follow the fields
  task automatic t_mandated();
    logic [7:0] ix [9] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h39, 8'h3e, 8'h42, 8'h32, 8'h3c};
    logic [15:0] vv [9] = '{16'hc0df, 16'h07fe, 16'h0300, 16'h0300, 16'h0020, 16'h0322,
      16'h01f4, 16'h0000, 16'h0003};
    for (int i = 0; i < 9; i++)
      wr(ix[i], vv[i], SCR_RESP_OKAY);
    for (int i = 0; i < 9; i++)
      rd(ix[i], vv[i], SCR_RESP_OKAY);
    rd(SCR_IDX_33, 16'h0080, SCR_RESP_OKAY);
    chk(drive, 6'h1f);
    chk(src_b, 2'h2);
    chk(src_a, 2'h0);
    wr(SCR_IDX_OUT_A, 16'hc8c0, SCR_RESP_OKAY);
    chk(src_a, 2'h1);
    chk(drive, 6'h00);
    for (int s = 0; s < 2; s++)
    begin
      wr(SCR_IDX_OUT_B, 16'h07fc | 16'(s), SCR_RESP_OKAY);
      chk(src_b, 2'(s));
    end
    wr(8'h45, 16'h1234, SCR_RESP_SLVERR);
    rd(8'h2b, 16'h0000, SCR_RESP_SLVERR);
  endtask : t_mandated

  // Pin disregard only while the ignore bit is set and alignment is off
  task automatic t_pins();
    sync_in <= 1'b1;
    req_in <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({sync_used, req_used}, 2'b00);
    rd(SCR_IDX_IRQ_STAT, 16'h000c, SCR_RESP_OKAY);
    wr(SCR_IDX_PIN_IGN, 16'h0001, SCR_RESP_OKAY);
    @(posedge aclk);
    chk({sync_used, req_used}, 2'b11);
    wr(SCR_IDX_PIN_IGN, 16'h8001, SCR_RESP_OKAY);
    phase_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({sync_used, req_used}, 2'b11);
    sync_in <= 1'b0;
    req_in <= 1'b0;
    phase_en <= 1'b0;
    @(posedge aclk);
  endtask : t_pins

  // One quarter-period pulse, then settle
  task automatic pulse();
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse

  // Lock wait of three units, both lock kinds, interrupt mask and clear
  task automatic t_lock();
    wr(SCR_IDX_IRQ_STAT, 16'h000f, SCR_RESP_OKAY);
    wr(SCR_IDX_LD_KIND, 16'h0000, SCR_RESP_OKAY);
    cal_done <= 1'b1;
    repeat (2) @(posedge aclk);
    pulse();
    pulse();
    chk(lock, 1'b0);
    pulse();
    chk(lock, 1'b1);
    rd(SCR_IDX_IRQ_STAT, 16'h0001, SCR_RESP_OKAY);
    chk(irq, 1'b0);
    wr(SCR_IDX_IRQ_MASK, 16'h0001, SCR_RESP_OKAY);
    chk(irq, 1'b1);
    wr(SCR_IDX_IRQ_STAT, 16'h0001, SCR_RESP_OKAY);
    chk(irq, 1'b0);
    wr(SCR_IDX_LD_KIND, 16'h0001, SCR_RESP_OKAY);
    @(posedge aclk);
    chk(lock, 1'b0);
    rd(SCR_IDX_IRQ_STAT, 16'h0002, SCR_RESP_OKAY);
    vtune <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(lock, 1'b1);
    cal_done <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(lock, 1'b0);
  endtask : t_lock

  // Clock enable low stalls a pending write; upper-byte strobe alone lands
  task automatic t_freeze();
    ce <= 1'b0;
    awaddr <= {SCR_IDX_35, 2'b00};
    wdata <= 32'h0000a5c3;
    wstrb <= 4'h2;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, awready}, 32'h0);
    ce <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, SCR_RESP_OKAY});
    bready <= 1'b0;
    @(posedge aclk);
    rd(SCR_IDX_35, 16'ha500, SCR_RESP_OKAY);
  endtask : t_freeze

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Watchdog, far beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial
  begin
    do_reset();
    t_reset_values();
    t_modulator();
    t_mandated();
    t_pins();
    t_lock();
    t_freeze();
    do_reset();
    t_reset_values();
    test_done();
  end
endmodule : scr_config_regs_tb
`default_nettype wire
